// File: core/input_clock_qualifier.sv
// input clock qualification, monitors and master clock control
`include "clkq_map.svh"
`timescale 1ns/100ps
module input_clock_qualifier (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // register port
  input clkq_pkg::reg_req_t bus,
  output logic [31:0] rdata,
  // reference clock and loss pins
  input wire logic [2:0] ref_in,
  input wire logic [3:0] gp_in,
  // dpll side
  input wire logic [1:0] dpll_sel_ref,
  input wire logic dpll_sel_valid,
  input wire logic dpll_locked,
  output logic [2:0] ref_edge,
  output logic [2:0] selectable,
  // master clock control
  output logic ref_doubler_en,
  output logic master_clk_sel,
  output logic ring_osc_en,
  // host request
  output logic validity_event
);
  clkq_pkg::state_t st;
  clkq_pkg::state_t next_st;
  logic [2:0] los_rt;
  logic [2:0] act_v;
  logic [2:0] freq_v;
  logic [2:0] all_v;
  logic a_end;
  logic f_end;

  // predivider terminal count for divide by 1, 2, 4, 8
  function automatic logic [2:0] div_lim(input logic [1:0] sel);
    unique case (sel)
      2'h0: div_lim = 3'h0;
      2'h1: div_lim = 3'h1;
      2'h2: div_lim = 3'h3;
      2'h3: div_lim = 3'h7;
    endcase
  endfunction : div_lim

  // percent check, threshold clamped into its legal range
  function automatic logic pct_ok(input logic [15:0] cnt,
                                  input logic [15:0] nom,
                                  input logic [4:0] pct);
    logic [15:0] d;
    logic [4:0] p;
    logic [22:0] lhs;
    logic [22:0] rhs;
    d = (cnt > nom) ? cnt - nom : nom - cnt;
    p = pct;
    if (p < `PCT_MIN) begin
      p = `PCT_MIN;
    end
    if (p > `PCT_MAX) begin
      p = `PCT_MAX;
    end
    lhs = 23'(d) * `PCT_SCALE;
    rhs = 23'(nom) * 23'(p);
    pct_ok = (lhs <= rhs);
  endfunction : pct_ok

  // loss level of one pin, per its config code
  function automatic logic pin_loss(input logic [3:0] cfg,
                                    input logic lvl);
    if (cfg == `GP_INV) begin
      pin_loss = ~lvl;
    end else if (cfg == `GP_IN) begin
      pin_loss = lvl;
    end else begin
      pin_loss = 1'b0;
    end
  endfunction : pin_loss

  // byte address of a per-input register
  function automatic logic [7:0] in_adr(input int i,
                                        input logic [7:0] ofs);
    in_adr = `OFS_IN_BASE + 8'(i) * `OFS_IN_STRIDE + ofs;
  endfunction : in_adr

  // all next-state logic; clears first so hardware sets win
  always_comb begin
    logic [2:0] clr_lat;
    logic [2:0] clr_lkto;
    logic rise;
    logic fall;
    logic hit;
    logic [2:0] src;
    logic sel;
    clr_lat = 3'h0;
    clr_lkto = 3'h0;
    rise = 1'b0;
    fall = 1'b0;
    hit = 1'b0;
    src = 3'h0;
    sel = 1'b0;
    los_rt = 3'h0;
    act_v = 3'h0;
    freq_v = 3'h0;
    all_v = 3'h0;
    next_st = st;
    next_st.rdata = 32'h0;
    // register writes
    if (bus.wr) begin
      unique case (bus.addr)
        `OFS_MASTER: next_st.mcr = bus.wdata[2:0];
        `OFS_IEN: next_st.ien = bus.wdata[2:0];
        `OFS_GPCFG: next_st.gpcfg = bus.wdata[15:0];
        `OFS_AWIN: next_st.awin = bus.wdata[15:0];
        `OFS_AMAX: next_st.amax = bus.wdata[15:0];
        `OFS_FWIN: next_st.fwin = bus.wdata[15:0];
        `OFS_VTIME: next_st.vtime = bus.wdata[15:0];
        `OFS_LKSET: next_st.lkset = bus.wdata[15:0];
        `OFS_MANUAL: next_st.manual = bus.wdata[2:0];
        `OFS_EVMASK: next_st.mask = bus.wdata[2:0];
        `OFS_VALSTAT: begin
          clr_lat = bus.wdata[`POS_VAL_LAT +: 3];
        end
        default: begin
        end
      endcase
      // per-input registers sit at base plus stride times index
      for (int i = 0; i < 3; i++) begin
        if (bus.addr == in_adr(i, `OFS_CR1)) begin
          next_st.cr1[i] = bus.wdata[2:0];
        end
        if (bus.addr == in_adr(i, `OFS_MON)) begin
          next_st.mon[i] = bus.wdata[9:0];
        end
        if (bus.addr == in_adr(i, `OFS_NOM)) begin
          next_st.nom[i] = bus.wdata[15:0];
        end
        if (bus.addr == in_adr(i, `OFS_STAT)) begin
          clr_lkto[i] = bus.wdata[5];
        end
      end
    end
    // shared window timers; a zero length acts as one cycle
    a_end = ({1'b0, st.atmr} + 17'h1) >= {1'b0, st.awin};
    f_end = ({1'b0, st.ftmr} + 17'h1) >= {1'b0, st.fwin};
    next_st.atmr = a_end ? 16'h0 : st.atmr + 16'h1;
    next_st.ftmr = f_end ? 16'h0 : st.ftmr + 16'h1;
    // pin synchronisers
    for (int p = 0; p < 4; p++) begin
      next_st.gs[p] = {st.gs[p][0], gp_in[p]};
    end
    next_st.latched = st.latched & ~clr_lat;
    next_st.lkto = st.lkto & ~clr_lkto;
    for (int i = 0; i < 3; i++) begin
      next_st.rs[i] = {st.rs[i][0], ref_in[i]};
      next_st.rprev[i] = st.rs[i][1];
      // chosen edge, gated by enable, then predivided
      rise = st.rs[i][1] & ~st.rprev[i];
      fall = ~st.rs[i][1] & st.rprev[i];
      hit = st.ien[i] & (st.cr1[i][`BIT_POL] ? fall : rise);
      next_st.edge_out[i] = 1'b0;
      if (hit) begin
        if (st.pdc[i] >= div_lim(st.cr1[i][`POS_PREDIV +: 2])) begin
          next_st.pdc[i] = 3'h0;
          next_st.edge_out[i] = 1'b1;
        end else begin
          next_st.pdc[i] = st.pdc[i] + 3'h1;
        end
      end
      // loss source: code n+1 selects pin n, zero means none
      src = st.mon[i][`POS_LOSSRC +: 3];
      if (src != 3'h0 && src <= 3'h4) begin
        los_rt[i] = pin_loss(st.gpcfg[4 * (src - 3'h1) +: 4],
                             st.gs[src - 3'h1][1]);
      end
      // activity: count must be non-zero and not above the limit
      if (los_rt[i]) begin
        next_st.acnt[i] = 16'h0;
        next_st.araw[i] = 1'b0;
      end else if (a_end) begin
        next_st.araw[i] = (st.acnt[i] != 16'h0) &&
                          (st.acnt[i] <= st.amax);
        // an edge on the closing cycle opens the next window, not lost
        next_st.acnt[i] = {15'h0, st.edge_out[i]};
      end else if (st.edge_out[i] && st.acnt[i] != 16'hFFFF) begin
        next_st.acnt[i] = st.acnt[i] + 16'h1;
      end
      act_v[i] = ~los_rt[i] &
                 (~st.mon[i][`BIT_ACTEN] | st.araw[i]);
      // frequency: restarts whenever activity is not valid
      if (!act_v[i]) begin
        next_st.fcnt[i] = 16'h0;
        next_st.fraw[i] = 1'b0;
      end else if (f_end) begin
        next_st.fraw[i] = pct_ok(st.fcnt[i], st.nom[i],
                                 st.mon[i][`POS_PCT +: 5]);
        // same carry of the closing-cycle edge as the activity count
        next_st.fcnt[i] = {15'h0, st.edge_out[i]};
      end else if (st.edge_out[i] && st.fcnt[i] != 16'hFFFF) begin
        next_st.fcnt[i] = st.fcnt[i] + 16'h1;
      end
      freq_v[i] = act_v[i] &
                  (~st.mon[i][`BIT_FRQEN] | st.fraw[i]);
      // lock timer runs only while selected and unlocked
      sel = dpll_sel_valid && (dpll_sel_ref == 2'(i));
      if (sel && !dpll_locked && st.lkset != 16'h0) begin
        if (st.lcnt[i] + 16'h1 >= st.lkset) begin
          next_st.lkto[i] = 1'b1;
        end else begin
          next_st.lcnt[i] = st.lcnt[i] + 16'h1;
        end
      end else begin
        next_st.lcnt[i] = 16'h0;
      end
      all_v[i] = st.ien[i] & freq_v[i] & ~st.lkto[i];
      // validation timer; zero time validates next cycle
      if (!all_v[i]) begin
        next_st.vcnt[i] = 16'h0;
        next_st.timed[i] = 1'b0;
      end else if (st.vcnt[i] >= st.vtime) begin
        next_st.timed[i] = 1'b1;
      end else begin
        next_st.vcnt[i] = st.vcnt[i] + 16'h1;
      end
      if (next_st.timed[i] != st.timed[i]) begin
        next_st.latched[i] = 1'b1;
      end
    end
    // manual invalid mask blocks automatic choice
    next_st.sel_ok = st.timed & st.manual;
    next_st.event_out = |(st.latched & st.mask);
    // register reads, data in the following cycle
    if (bus.rd) begin
      unique case (bus.addr)
        `OFS_MASTER: next_st.rdata = {29'h0, st.mcr};
        `OFS_IEN: next_st.rdata = {29'h0, st.ien};
        `OFS_GPCFG: next_st.rdata = {16'h0, st.gpcfg};
        `OFS_AWIN: next_st.rdata = {16'h0, st.awin};
        `OFS_AMAX: next_st.rdata = {16'h0, st.amax};
        `OFS_FWIN: next_st.rdata = {16'h0, st.fwin};
        `OFS_VTIME: next_st.rdata = {16'h0, st.vtime};
        `OFS_LKSET: next_st.rdata = {16'h0, st.lkset};
        `OFS_MANUAL: next_st.rdata = {29'h0, st.manual};
        `OFS_EVMASK: next_st.rdata = {29'h0, st.mask};
        `OFS_VALSTAT: begin
          next_st.rdata = {21'h0, st.timed, 1'b0, st.latched,
                           1'b0, all_v};
        end
        default: begin
        end
      endcase
      // per-input read decode, same layout as the writes
      for (int i = 0; i < 3; i++) begin
        if (bus.addr == in_adr(i, `OFS_CR1)) begin
          next_st.rdata = {29'h0, st.cr1[i]};
        end
        if (bus.addr == in_adr(i, `OFS_MON)) begin
          next_st.rdata = {22'h0, st.mon[i]};
        end
        if (bus.addr == in_adr(i, `OFS_NOM)) begin
          next_st.rdata = {16'h0, st.nom[i]};
        end
        if (bus.addr == in_adr(i, `OFS_STAT)) begin
          next_st.rdata = {26'h0, st.lkto[i], st.timed[i], all_v[i],
                           freq_v[i], act_v[i], los_rt[i]};
        end
      end
    end
  end

  // one register for all state; reset leaves ring osc running
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st <= '0;
      st.cr1 <= '0;
      st.awin <= `RST_AWIN;
      st.amax <= `RST_AMAX;
      st.fwin <= `RST_FWIN;
      st.vtime <= `RST_VTIME;
      st.lkset <= `RST_LKSET;
      st.manual <= `RST_MANUAL;
      for (int i = 0; i < 3; i++) begin
        st.nom[i] <= `RST_NOM;
        st.mon[i] <= {`RST_PCT, 5'h0};
      end
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from state
  assign rdata = st.rdata;
  assign ref_edge = st.edge_out;
  assign selectable = st.sel_ok;
  assign validity_event = st.event_out;
  assign ref_doubler_en = st.mcr[`BIT_DBL];
  // master clock mux is software driven, never automatic
  assign master_clk_sel = st.mcr[`BIT_MCSEL];
  assign ring_osc_en = ~st.mcr[`BIT_ROSCD];

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  sequence s_held0;
    (st.vtime == 16'h0 && all_v[0]) [*2];
  endsequence

  a_los_kills_all: assert property ((los_rt & all_v) == 3'h0)
    else $error("loss pin did not invalidate input");
  a_act_gates_freq: assert property ((~act_v & freq_v) == 3'h0)
    else $error("frequency valid while activity invalid");
  a_mon_off_valid: assert property (
    (~los_rt & ~act_v & ~{st.mon[2][0], st.mon[1][0], st.mon[0][0]})
    == 3'h0)
    else $error("disabled activity monitor reported invalid");
  a_enable_gate: assert property ((~st.ien & all_v) == 3'h0)
    else $error("disabled input reported valid");
  a_timed_needs_all: assert property (
    (st.timed & ~$past(all_v)) == 3'h0)
    else $error("timed valid without combined valid");
  a_zero_delay: assert property (s_held0 |-> st.timed[0])
    else $error("zero validation time did not validate");
  a_latch_change: assert property (
    (($past(st.timed) ^ st.timed) & ~st.latched) == 3'h0)
    else $error("validity change not latched");
  a_manual_block: assert property (
    (st.sel_ok & ~$past(st.manual)) == 3'h0)
    else $error("manually invalid input selectable");
  a_lkto_invalid: assert property ((st.lkto & all_v) == 3'h0)
    else $error("timed-out input still valid");

  // start-up, register port, edge pulse, sticky flag and selection checks
  a_ring_start: assert property (
    $past(reset) |-> ring_osc_en && !master_clk_sel)
    else $error("ring oscillator not running after reset");
  a_rdata_idle: assert property (
    !$past(bus.rd) |-> st.rdata == 32'h0)
    else $error("read data present without a read strobe");
  a_edge_single: assert property (
    (st.edge_out & $past(st.edge_out)) == 3'h0)
    else $error("reference edge pulse longer than one cycle");
  a_lkto_sticky: assert property (
    $past(st.lkto[0]) && !$past(bus.wr) |-> st.lkto[0])
    else $error("lock timeout flag dropped without a clear");
  a_sel_needs_timed: assert property (
    (st.sel_ok & ~$past(st.timed)) == 3'h0)
    else $error("input selectable before validation time");
endmodule : input_clock_qualifier

// File: inc/clkq_map.svh
// register offsets, field positions, reset values and limits
`ifndef CLKQ_MAP_SVH
`define CLKQ_MAP_SVH
// global registers
`define OFS_MASTER 8'h00
`define OFS_IEN 8'h04
`define OFS_GPCFG 8'h40
`define OFS_AWIN 8'h44
`define OFS_AMAX 8'h48
`define OFS_FWIN 8'h4C
`define OFS_VTIME 8'h50
`define OFS_LKSET 8'h54
`define OFS_MANUAL 8'h58
`define OFS_VALSTAT 8'h5C
`define OFS_EVMASK 8'h60
// per-input blocks: base + stride * input
`define OFS_IN_BASE 8'h10
`define OFS_IN_STRIDE 8'h10
`define OFS_CR1 8'h00
`define OFS_MON 8'h04
`define OFS_NOM 8'h08
`define OFS_STAT 8'h0C
// master control bits
`define BIT_DBL 0
`define BIT_MCSEL 1
`define BIT_ROSCD 2
// input control fields
`define BIT_POL 0
`define POS_PREDIV 1
`define BIT_ACTEN 0
`define BIT_FRQEN 1
`define POS_LOSSRC 2
`define POS_PCT 5
// validity status fields
`define POS_VAL_RT 0
`define POS_VAL_LAT 4
`define POS_VAL_TMD 8
// pin codes
`define GP_IN 4'h0
`define GP_INV 4'h1
// reset values
`define RST_PCT 5'h0A
`define RST_AWIN 16'h0010
`define RST_AMAX 16'h0008
`define RST_FWIN 16'h0100
`define RST_NOM 16'h0040
`define RST_VTIME 16'h0000
`define RST_LKSET 16'h0000
`define RST_MANUAL 3'h7
// percent threshold limits
`define PCT_MIN 5'h01
`define PCT_MAX 5'h14
`define PCT_SCALE 23'h000064
`endif

// File: inc/clkq_pkg.sv
// types shared by the input clock qualifier
package clkq_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [2:0] mcr;
    logic [2:0] ien;
    logic [2:0][2:0] cr1;
    logic [2:0][9:0] mon;
    logic [2:0][15:0] nom;
    logic [15:0] gpcfg;
    logic [15:0] awin;
    logic [15:0] amax;
    logic [15:0] fwin;
    logic [15:0] vtime;
    logic [15:0] lkset;
    logic [2:0] manual;
    logic [2:0] mask;
    logic [2:0][1:0] rs;
    logic [2:0] rprev;
    logic [3:0][1:0] gs;
    logic [2:0][2:0] pdc;
    logic [2:0] edge_out;
    logic [15:0] atmr;
    logic [15:0] ftmr;
    logic [2:0][15:0] acnt;
    logic [2:0][15:0] fcnt;
    logic [2:0][15:0] vcnt;
    logic [2:0][15:0] lcnt;
    logic [2:0] araw;
    logic [2:0] fraw;
    logic [2:0] timed;
    logic [2:0] latched;
    logic [2:0] lkto;
    logic [2:0] sel_ok;
    logic event_out;
    logic [31:0] rdata;
  } state_t;
endpackage : clkq_pkg

// File: verif/ref_source_model.sv
// behavioural reference clock sources and external loss indicators
`timescale 1ns/100ps
module ref_source_model (
  // source control from the bench
  input wire logic [2:0] run,
  input wire logic [2:0] level,
  input wire logic [2:0][9:0] half_ns,
  input wire logic [3:0] loss,
  // pins towards the block
  output logic [2:0] ref_out,
  output logic [3:0] gp_out
);
  // loss indicators are active low, as line receivers usually drive them
  assign gp_out = ~loss;
  // a stopped source holds the commanded level, so edges can be placed
  // by hand; running sources are far below the predivider limit
  for (genvar i = 0; i < 3; i++) begin : g_src
    logic q = 1'b0;
    assign ref_out[i] = q;
    always begin
      if (run[i]) begin
        #(half_ns[i]) q = ~q;
      end else begin
        q = level[i];
        @(run[i] or level[i]);
      end
    end
  end
endmodule : ref_source_model

// File: verif/tb_top.sv
// self-checking bench for the input clock qualifier
`timescale 1ns/100ps
`include "clkq_map.svh"
module tb_top;
  localparam logic [7:0] st0 = `OFS_IN_BASE + `OFS_STAT;
  localparam logic [7:0] mn0 = `OFS_IN_BASE + `OFS_MON;
  localparam logic [7:0] nm0 = `OFS_IN_BASE + `OFS_NOM;
  localparam logic [7:0] cr1b = `OFS_IN_BASE + `OFS_IN_STRIDE + `OFS_CR1;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  clkq_pkg::reg_req_t bus = '0;
  logic [31:0] rdata;
  logic [2:0] ref_in, ref_edge, selectable;
  logic [3:0] gp_in;
  logic [1:0] dpll_sel_ref = 2'h0;
  logic dpll_sel_valid = 1'b0;
  logic dpll_locked = 1'b0;
  logic ref_doubler_en, master_clk_sel, ring_osc_en, validity_event;
  logic [2:0] run = 3'h0;
  logic [2:0] level = 3'h0;
  // all sources share one nominal rate
  logic [2:0][9:0] half_ns = {10'h1F4, 10'h1F4, 10'h1F4};
  logic [3:0] loss = 4'h0;
  int fail_count = 0;
  int cmp_count = 0;

  always #50 sys_clk = ~sys_clk;

  input_clock_qualifier i_dut (
    .sys_clk(sys_clk),
    .reset(reset),
    .bus(bus),
    .rdata(rdata),
    .ref_in(ref_in),
    .gp_in(gp_in),
    .dpll_sel_ref(dpll_sel_ref),
    .dpll_sel_valid(dpll_sel_valid),
    .dpll_locked(dpll_locked),
    .ref_edge(ref_edge),
    .selectable(selectable),
    .ref_doubler_en(ref_doubler_en),
    .master_clk_sel(master_clk_sel),
    .ring_osc_en(ring_osc_en),
    .validity_event(validity_event)
  );

  ref_source_model i_src (
    .run(run),
    .level(level),
    .half_ns(half_ns),
    .loss(loss),
    .ref_out(ref_in),
    .gp_out(gp_in)
  );

  task automatic complete_run();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // two idle cycles after the strobe let registered outputs settle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge sys_clk);
    bus.wr <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    @(negedge sys_clk);
    d = rdata;
    @(posedge sys_clk);
  endtask : rd

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask : rchk

  // monitors settle over whole windows, so poll with a bound
  task automatic poll(input logic [7:0] a, input logic [31:0] m, e);
    logic [31:0] d;
    int k;
    k = 0;
    do begin
      rd(a, d);
      k++;
    end while ((d & m) !== e && k < 250);
    chk(d & m, e);
    if ((d & m) !== e) complete_run();
  endtask : poll

  // hand-placed edges on a stopped source, pulses counted mid-cycle
  task automatic toggles(input int i, input int nt, input int exp);
    int n;
    n = 0;
    repeat (nt) begin
      level[i] <= ~level[i];
      repeat (8) begin
        @(negedge sys_clk);
        if (ref_edge[i] === 1'b1) n++;
      end
      @(posedge sys_clk);
    end
    chk(n, exp);
  endtask : toggles

  task automatic t_reset_values();
    chk({ref_doubler_en, master_clk_sel, ring_osc_en}, 3'h1);
    chk(selectable, 3'h0);
    rchk(`OFS_MASTER, 32'h0);
    rchk(`OFS_IEN, 32'h0);
    rchk(cr1b, 32'h0);
    rchk(mn0, 32'h140);
    rchk(nm0, 32'h40);
    rchk(`OFS_AMAX, 32'h8);
    rchk(`OFS_MANUAL, 32'h7);
    rchk(`OFS_VTIME, 32'h0);
    rchk(8'h70, 32'h0);
  endtask : t_reset_values

  task automatic t_master();
    // oscillator taken as stable here; ring oscillator kept
    wr(`OFS_MASTER, 32'h3);
    chk({ref_doubler_en, master_clk_sel, ring_osc_en}, 3'h7);
    wr(`OFS_MASTER, 32'h7);
    chk(ring_osc_en, 1'b0);
    rchk(`OFS_MASTER, 32'h7);
    wr(`OFS_MASTER, 32'h2);
    chk({ref_doubler_en, master_clk_sel, ring_osc_en}, 3'h3);
  endtask : t_master

  task automatic t_edges();
    toggles(1, 4, 0);
    wr(`OFS_IEN, 32'h2);
    toggles(1, 1, 1);
    toggles(1, 1, 0);
    wr(cr1b, 32'h1);
    toggles(1, 2, 1);
    wr(cr1b, 32'h2);
    toggles(1, 8, 2);
  endtask : t_edges

  task automatic t_monitors();
    wr(`OFS_AWIN, 32'h28);
    wr(`OFS_FWIN, 32'h64);
    wr(nm0, 32'hA);
    wr(mn0, 32'h283);
    wr(`OFS_IEN, 32'h3);
    run[0] <= 1'b1;
    poll(st0, 32'h1E, 32'h1E);
    chk(selectable[0], 1'b1);
    half_ns[0] <= 10'h12C;
    poll(st0, 32'h0E, 32'h02);
    run[0] <= 1'b0;
    poll(st0, 32'h0E, 32'h00);
    wr(mn0, 32'h280);
    poll(st0, 32'h1E, 32'h1E);
    wr(mn0, 32'h281);
    poll(st0, 32'h0E, 32'h00);
    wr(mn0, 32'h282);
    poll(st0, 32'h0E, 32'h02);
    wr(mn0, 32'h283);
    half_ns[0] <= 10'h096;
    run[0] <= 1'b1;
    poll(st0, 32'h0E, 32'h00);
    half_ns[0] <= 10'h1F4;
    poll(st0, 32'h1E, 32'h1E);
  endtask : t_monitors

  task automatic t_latch();
    rchk(`OFS_VALSTAT, 32'h333);
    wr(`OFS_VALSTAT, 32'h10);
    rchk(`OFS_VALSTAT, 32'h323);
    wr(`OFS_EVMASK, 32'h1);
    chk(validity_event, 1'b0);
    wr(`OFS_EVMASK, 32'h2);
    chk(validity_event, 1'b1);
    wr(`OFS_VALSTAT, 32'h20);
    chk(validity_event, 1'b0);
    wr(`OFS_MANUAL, 32'h6);
    chk(selectable, 3'h2);
    wr(`OFS_MANUAL, 32'h7);
    chk(selectable, 3'h3);
  endtask : t_latch

  task automatic t_los_timer();
    int n;
    wr(`OFS_GPCFG, 32'h10);
    wr(mn0, 32'h288);
    wr(`OFS_VTIME, 32'h14);
    loss[1] <= 1'b1;
    poll(st0, 32'h0F, 32'h01);
    // selectable trails the status read by two edges
    @(posedge sys_clk);
    chk(selectable[0], 1'b0);
    loss[1] <= 1'b0;
    n = 0;
    @(posedge sys_clk);
    while (selectable[0] !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      n++;
    end
    chk(n >= 21 && n <= 32, 1'b1);
    if (n == 40) complete_run();
  endtask : t_los_timer

  task automatic t_lock_timeout();
    wr(`OFS_LKSET, 32'h5);
    dpll_sel_valid <= 1'b1;
    poll(st0, 32'h28, 32'h20);
    dpll_locked <= 1'b1;
    wr(st0, 32'h20);
    chk(selectable[0], 1'b0);
    poll(st0, 32'h28, 32'h08);
  endtask : t_lock_timeout

  // main sequence; register access starts right after reset
  initial begin
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    t_reset_values();
    t_master();
    t_edges();
    t_monitors();
    t_latch();
    t_los_timer();
    t_lock_timeout();
    complete_run();
  end

  // hang guard
  initial begin
    repeat (60000) @(posedge sys_clk);
    fail_count++;
    complete_run();
  end
endmodule : tb_top
